// ### ifb_top.sv
`timescale 1ns/1ns
`include "ifb_params.svh"
// Interrupt flag and enable register bank.
module ifb_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset.
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // Data memory access from the core.
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  input  wire logic [7:0]        WDATA,
  output logic      [7:0]        RDATA,
  // External interrupt pins.
  input  wire logic [1:0]        EXT_IRQ_PINS,
  // Internal peripheral request pulses.
  input  wire logic              AUTOCONV_EVT,
  input  wire logic              TB0_EVT,
  input  wire logic              TB1_EVT,
  input  wire logic [3:0]        STM_EVT,
  input  wire logic [3:0]        MFB_EVT,
  // Requests toward the core.
  output logic                   IRQ_REQ,
  output logic      [6:0]        IRQ_PEND
);

  // The index is taken from ADDR[3:0], so a narrower address could not supply every index bit.
  if (ADDR_W < 4) begin : g_addr_check
    $error("ifb_top: ADDR_W must be at least 4");
  end

  // Reset image of a full byte; narrower registers take their low bits from it.
  localparam logic [7:0] reset_byte = `IFB_RESET_VAL;

  // Stored fields, their next values and the decode helpers.
  logic [`IFB_EDGE_WIDTH-1:0] edge_sel_r;    // Edge codes for both pins.
  logic [`IFB_EDGE_WIDTH-1:0] edge_sel_nxt;  // Next edge codes.
  logic [`IFB_A_WIDTH-1:0]    ctl_a_r;       // Primary control A, bit 7 absent.
  logic [`IFB_A_WIDTH-1:0]    ctl_a_nxt;     // Next primary control A.
  logic [7:0]                 ctl_b_r;       // Primary control B.
  logic [7:0]                 ctl_b_nxt;     // Next primary control B.
  logic [7:0]                 mf_a_r;        // Multi-function control A.
  logic [7:0]                 mf_a_nxt;      // Next multi-function control A.
  logic [7:0]                 mf_b_r;        // Multi-function control B.
  logic [7:0]                 mf_b_nxt;      // Next multi-function control B.
  logic [7:0]                 rdata_r;       // Read data register.
  logic [7:0]                 rdata_nxt;     // Next read data.
  logic                       irq_r;         // Combined request register.
  logic                       irq_nxt;       // Next combined request.
  logic [6:0]                 pend_r;        // Per-source pending register.
  logic [6:0]                 pend_nxt;      // Next per-source pending.
  logic [1:0]                 pin_evt;       // Selected edge pulses from the pins.
  logic [3:0]                 idx;           // Register index taken from the address.
  logic                       mf0_any;       // Some enabled sub-source in bank A pending.
  logic                       mf1_any;       // Some enabled sub-source in bank B pending.

  assign idx = ADDR[3:0];

  // One edge detector per external pin; only pins feed the external flags.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      ifb_edge u_edge (
        .clk  (REF_CLK),
        .rst  (RST),
        .pin  (EXT_IRQ_PINS[g]),
        .code (edge_sel_r[2*g+1 -: 2]),
        .evt  (pin_evt[g])
      );
    end
  endgenerate

  // Register update: software writes first, then hardware sets on top.
  // Doing the sets last means an event in the cycle of a clearing write is never lost;
  // the cost is that software must clear a flag again if the event keeps arriving.
  always_comb begin
    edge_sel_nxt = edge_sel_r;
    ctl_a_nxt    = ctl_a_r;
    ctl_b_nxt    = ctl_b_r;
    mf_a_nxt     = mf_a_r;
    mf_b_nxt     = mf_b_r;
    mf0_any      = |(mf_a_r[`IFB_MF_FLAG_LO +: 4] & mf_a_r[`IFB_MF_EN_LO +: 4]);
    mf1_any      = |(mf_b_r[`IFB_MF_FLAG_LO +: 4] & mf_b_r[`IFB_MF_EN_LO +: 4]);
    // Only one register is written per cycle; unmapped indices leave everything alone.
    if (WR_EN) begin
      if (idx == `IFB_IDX_EDGE) begin
        // Edge codes for both pins; the upper nibble has no storage.
        // both pin codes
        edge_sel_nxt = WDATA[`IFB_EDGE_WIDTH-1:0];
      end else if (idx == `IFB_IDX_CTL_A) begin
        // Global enable, source enables and the three flags; bit 7 has no storage.
        // global enable, per-source enables and flags
        ctl_a_nxt = WDATA[`IFB_A_WIDTH-1:0];
      end else if (idx == `IFB_IDX_CTL_B) begin
        // Time base and multi-function enables and flags.
        ctl_b_nxt = WDATA;
      end else if (idx == `IFB_IDX_MF_A) begin
        // Timer comparator sub-sources.
        // sub-source bank A
        mf_a_nxt = WDATA;
      end else if (idx == `IFB_IDX_MF_B) begin
        // Converter, serial, data memory and low voltage sub-sources.
        mf_b_nxt = WDATA;
      end
    end
    // Hardware sets win over a clearing write in the same cycle.
    // pin zero flag
    ctl_a_nxt[`IFB_A_P0_FLAG] = ctl_a_nxt[`IFB_A_P0_FLAG] | pin_evt[0];
    ctl_a_nxt[`IFB_A_P1_FLAG] = ctl_a_nxt[`IFB_A_P1_FLAG] | pin_evt[1];
    ctl_a_nxt[`IFB_A_AC_FLAG] = ctl_a_nxt[`IFB_A_AC_FLAG] | AUTOCONV_EVT;
    ctl_b_nxt[`IFB_B_TB0_FLAG] = ctl_b_nxt[`IFB_B_TB0_FLAG] | TB0_EVT;
    ctl_b_nxt[`IFB_B_TB1_FLAG] = ctl_b_nxt[`IFB_B_TB1_FLAG] | TB1_EVT;
    mf_a_nxt[`IFB_MF_FLAG_LO +: 4] = mf_a_nxt[`IFB_MF_FLAG_LO +: 4] | STM_EVT;
    mf_b_nxt[`IFB_MF_FLAG_LO +: 4] = mf_b_nxt[`IFB_MF_FLAG_LO +: 4] | MFB_EVT;
    // A summary flag is set again while any enabled sub-source in its bank is still pending,
    // so software must clear the sub-flag before the summary flag will stay clear.
    // summary flags
    ctl_b_nxt[`IFB_B_MF0_FLAG] = ctl_b_nxt[`IFB_B_MF0_FLAG] | mf0_any;
    ctl_b_nxt[`IFB_B_MF1_FLAG] = ctl_b_nxt[`IFB_B_MF1_FLAG] | mf1_any;
  end

  // Request generation from the current flags and enables.
  // Apart from the summary flags, which need an enabled sub-source, flags are set whatever the enables say; requests are gated here.
  // The requests are registered below, so they trail the flags by one cycle.
  // That delay is the price of handing the core clean levels.
  always_comb begin
    pend_nxt = {ctl_b_r[`IFB_B_MF1_FLAG] & ctl_b_r[`IFB_B_MF1_EN],
                ctl_b_r[`IFB_B_MF0_FLAG] & ctl_b_r[`IFB_B_MF0_EN],
                ctl_b_r[`IFB_B_TB1_FLAG] & ctl_b_r[`IFB_B_TB1_EN],
                ctl_b_r[`IFB_B_TB0_FLAG] & ctl_b_r[`IFB_B_TB0_EN],
                ctl_a_r[`IFB_A_AC_FLAG] & ctl_a_r[`IFB_A_AC_EN],
                ctl_a_r[`IFB_A_P1_FLAG] & ctl_a_r[`IFB_A_P1_EN],
                ctl_a_r[`IFB_A_P0_FLAG] & ctl_a_r[`IFB_A_P0_EN]};
    irq_nxt = ctl_a_r[`IFB_A_GLOBAL_EN] & (|pend_nxt);
  end

  // Read path; unmapped indices and absent bits read as zero.
  // A read in the cycle of a write returns the old contents, since it looks at the registers.
  always_comb begin
    rdata_nxt = rdata_r;
    // Without a read strobe the last value read simply stands.
    if (RD_EN) begin
      if (idx == `IFB_IDX_EDGE) begin
        rdata_nxt = {4'h0, edge_sel_r};
      end else if (idx == `IFB_IDX_CTL_A) begin
        // Bit 7 has no storage and reads zero.
        rdata_nxt = {1'b0, ctl_a_r};
      end else if (idx == `IFB_IDX_CTL_B) begin
        // Full byte of time base and multi-function bits.
        rdata_nxt = ctl_b_r;
      end else if (idx == `IFB_IDX_MF_A) begin
        // Timer comparator sub-sources.
        rdata_nxt = mf_a_r;
      end else if (idx == `IFB_IDX_MF_B) begin
        // Remaining sub-sources.
        rdata_nxt = mf_b_r;
      end else begin
        // Nothing stands at this index.
        rdata_nxt = 8'h00;
      end
    end
  end

  // Register bank state; every implemented bit resets to zero so nothing is enabled or pending.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      edge_sel_r <= reset_byte[`IFB_EDGE_WIDTH-1:0];
      ctl_a_r    <= reset_byte[`IFB_A_WIDTH-1:0];
      ctl_b_r    <= reset_byte;
      mf_a_r     <= reset_byte;
      mf_b_r     <= reset_byte;
    end else begin
      edge_sel_r <= edge_sel_nxt;
      ctl_a_r    <= ctl_a_nxt;
      ctl_b_r    <= ctl_b_nxt;
      mf_a_r     <= mf_a_nxt;
      mf_b_r     <= mf_b_nxt;
    end
  end

  // Request registers; they give the core glitch-free levels at the price of one cycle of delay.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      // No request may reach the core during or right after reset.
      irq_r  <= 1'b0;
      pend_r <= 7'h00;
    end else begin
      irq_r  <= irq_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Read data register; it holds the last value read until the next read strobe.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r <= reset_byte;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Every output comes straight from a flip-flop.
  assign RDATA    = rdata_r;
  assign IRQ_REQ  = irq_r;
  assign IRQ_PEND = pend_r;

endmodule

// ### ifb_params.svh
`ifndef IFB_PARAMS_SVH
`define IFB_PARAMS_SVH

// Register indices in the special purpose data memory window.
`define IFB_IDX_EDGE     4'h0
`define IFB_IDX_CTL_A    4'h1
`define IFB_IDX_CTL_B    4'h2
`define IFB_IDX_MF_A     4'h3
`define IFB_IDX_MF_B     4'h4

// Field positions in the edge select register.
`define IFB_EDGE_P0_LO   0
`define IFB_EDGE_P1_LO   2
`define IFB_EDGE_WIDTH   4

// Field positions in primary control register A.
`define IFB_A_GLOBAL_EN  0
`define IFB_A_P0_EN      1
`define IFB_A_P1_EN      2
`define IFB_A_AC_EN      3
`define IFB_A_P0_FLAG    4
`define IFB_A_P1_FLAG    5
`define IFB_A_AC_FLAG    6
`define IFB_A_WIDTH      7

// Field positions in primary control register B.
`define IFB_B_TB0_EN     0
`define IFB_B_TB1_EN     1
`define IFB_B_MF0_EN     2
`define IFB_B_MF1_EN     3
`define IFB_B_TB0_FLAG   4
`define IFB_B_TB1_FLAG   5
`define IFB_B_MF0_FLAG   6
`define IFB_B_MF1_FLAG   7

// Multi-function registers: enables low nibble, flags high nibble.
`define IFB_MF_EN_LO     0
`define IFB_MF_FLAG_LO   4

// Reset value of every implemented bit.
`define IFB_RESET_VAL    8'h00

`endif

// ### ifb_pkg.sv
package ifb_pkg;
  // Edge detection modes carried by a two-bit edge code.
  typedef enum logic [1:0] {
    IFB_EDGE_OFF     = 2'h0,
    IFB_EDGE_RISE    = 2'h1,
    IFB_EDGE_FALL    = 2'h2,
    IFB_EDGE_BOTH    = 2'h3
  } ifb_edge_mode_t;
endpackage

// ### ifb_edge.sv
`timescale 1ns/1ns
// Edge detector for one external interrupt pin.
module ifb_edge (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Pin level and the selected edge code.
  input  wire logic        pin,
  input  wire logic [1:0]  code,
  // One-cycle pulse on a selected edge.
  output logic             evt
);

  logic prev_r;    // Pin level of the previous cycle.
  logic prev_nxt;  // Next value of the previous level.
  logic rise;      // Low to high transition seen.
  logic fall;      // High to low transition seen.

  // The previous level always follows the pin, so a mode change never sees a stale level.
  always_comb begin
    prev_nxt = pin;
    rise     = pin & ~prev_r;
    fall     = ~pin & prev_r;
    // Edge code decode: off, rising, falling or both.
    case (ifb_pkg::ifb_edge_mode_t'(code))
      ifb_pkg::IFB_EDGE_RISE: begin
        evt = rise;
      end
      ifb_pkg::IFB_EDGE_FALL: begin
        evt = fall;
      end
      ifb_pkg::IFB_EDGE_BOTH: begin
        evt = rise | fall;
      end
      default: begin
        evt = 1'b0;
      end
    endcase
  end

  // Register the pin level; reset low, harmless since all codes reset to off.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

endmodule

// ### ifb_top_asserts.sv
`timescale 1ns/1ns
// Ties the pin, autoconversion and time base 0 requests and the edge select read value of the bank to their causes at the ports.
module ifb_top_chk #(
  parameter int ADDR_W = 4
) (
  // Clock and reset.
  input wire logic              REF_CLK,
  input wire logic              RST,
  // Register access.
  input wire logic              WR_EN,
  input wire logic              RD_EN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0]        WDATA,
  input wire logic [7:0]        RDATA,
  // Events in.
  input wire logic [1:0]        EXT_IRQ_PINS,
  input wire logic              AUTOCONV_EVT,
  input wire logic              TB0_EVT,
  input wire logic              TB1_EVT,
  input wire logic [3:0]        STM_EVT,
  input wire logic [3:0]        MFB_EVT,
  // Requests out.
  input wire logic              IRQ_REQ,
  input wire logic [6:0]        IRQ_PEND
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Reset must be watched while it is asserted, so it has no disable.
  reset_clears_out_a: assert property (disable iff (1'b0) RST |=> !IRQ_REQ && IRQ_PEND == 7'h00)
    else $error("requests not cleared by reset");
  edge_upper_zero_a: assert property (RD_EN && ADDR[3:0] == 4'h0 |=> RDATA[7:4] == 4'h0)
    else $error("edge select upper bits not zero");
  edge_code_kept_a: assert property (WR_EN && ADDR[3:0] == 4'h0 ##1 !WR_EN && !RD_EN
    ##1 RD_EN && !WR_EN && ADDR[3:0] == 4'h0 |=> RDATA[3:0] == $past(WDATA[3:0], 3))
    else $error("edge codes not stored");
  req_needs_pend_a: assert property (IRQ_REQ |-> IRQ_PEND != 7'h00)
    else $error("request without pending source");
  pin0_cause_a: assert property ($rose(IRQ_PEND[0]) |-> $past(WR_EN, 2)
    || $past(EXT_IRQ_PINS[0], 2) != $past(EXT_IRQ_PINS[0], 3))
    else $error("pin zero request without pin edge");
  pin1_cause_a: assert property ($rose(IRQ_PEND[1]) |-> $past(WR_EN, 2)
    || $past(EXT_IRQ_PINS[1], 2) != $past(EXT_IRQ_PINS[1], 3))
    else $error("pin one request without pin edge");
  autoconv_cause_a: assert property ($rose(IRQ_PEND[2]) |-> $past(WR_EN, 2) || $past(AUTOCONV_EVT, 2))
    else $error("autoconversion request without event");
  timebase_cause_a: assert property ($rose(IRQ_PEND[3]) |-> $past(WR_EN, 2) || $past(TB0_EVT, 2))
    else $error("time base request without event");
  flag_stands_a: assert property ($fell(IRQ_PEND[2]) |-> $past(WR_EN, 2))
    else $error("pending request dropped without a write");
endmodule

bind ifb_top ifb_top_chk #(.ADDR_W(ADDR_W)) i_ifb_top_chk (.*);

// ### ifb_pin_drv.sv
`timescale 1ns/1ns
// Drives the two external interrupt pins just after a clock edge.
module ifb_pin_drv (
  // Clock that paces the pin changes.
  input  wire logic       clk,
  // Levels on the two external interrupt pins.
  output logic      [1:0] pins
);
  initial pins = 2'h0;
  // Both pins move together, so one call tests both detectors.
  task automatic drive(input logic [1:0] lvl);
    @(posedge clk);
    pins <= lvl;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ac = 1'b0, irq;
  logic [3:0] addr = 4'h0, stm = 4'h0, mfb = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] pins, tbe = 2'h0;
  logic [6:0] pend;
  int         n_fail = 0, n_tests = 0;
  always #50 clk = ~clk;
  ifb_top i_ifb_top (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WR_EN(wr), .RD_EN(rd), .WDATA(wdata),
    .RDATA(rdata), .EXT_IRQ_PINS(pins), .AUTOCONV_EVT(ac), .TB0_EVT(tbe[0]), .TB1_EVT(tbe[1]),
    .STM_EVT(stm), .MFB_EVT(mfb), .IRQ_REQ(irq), .IRQ_PEND(pend));
  ifb_pin_drv i_ifb_pin_drv (.clk(clk), .pins(pins));
  // Compares one byte and counts the result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is registered, so it is looked at after the strobe's edge.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // Checks the request outputs as {IRQ_REQ, IRQ_PEND} after n edges.
  task automatic req_chk(input int n, input logic [7:0] e);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk({irq, pend}, e);
  endtask
  task automatic t_regs;
    for (int a = 0; a < 6; a++) rd_chk(a[3:0], 8'h00);
    wr_reg(4'h0, 8'hff);
    rd_chk(4'h0, 8'h0f);
    wr_reg(4'h1, 8'hff);
    rd_chk(4'h1, 8'h7f);
    req_chk(0, 8'h87);
    wr_reg(4'h1, 8'h00);
    req_chk(1, 8'h00);
    $display("test registers done");
  endtask
  // Every edge code against a rising and then a falling edge.
  task automatic t_pins;
    logic r;
    logic f;
    for (int c = 0; c < 4; c++) begin
      r = c[0];
      f = c[1];
      wr_reg(4'h0, {4'h0, c[1:0], c[1:0]});
      wr_reg(4'h1, 8'h07);
      i_ifb_pin_drv.drive(2'h3);
      req_chk(3, r ? 8'h83 : 8'h00);
      rd_chk(4'h1, r ? 8'h37 : 8'h07);
      wr_reg(4'h1, 8'h07);
      i_ifb_pin_drv.drive(2'h0);
      req_chk(3, f ? 8'h83 : 8'h00);
      rd_chk(4'h1, f ? 8'h37 : 8'h07);
      wr_reg(4'h1, 8'h00);
    end
    $display("test pins done");
  endtask
  task automatic t_autoconv;
    wr_reg(4'h1, 8'h08);
    @(posedge clk);
    ac <= 1'b1;
    @(posedge clk);
    ac <= 1'b0;
    req_chk(1, 8'h04);
    rd_chk(4'h1, 8'h48);
    wr_reg(4'h1, 8'h49);
    req_chk(1, 8'h84);
    wr_reg(4'h1, 8'h09);
    req_chk(1, 8'h00);
    $display("test autoconv done");
  endtask
  task automatic t_timebase;
    wr_reg(4'h2, 8'h01);
    @(posedge clk);
    tbe <= 2'h3;
    stm <= 4'h1;
    mfb <= 4'h8;
    @(posedge clk);
    tbe <= 2'h0;
    stm <= 4'h0;
    mfb <= 4'h0;
    req_chk(1, 8'h88);
    rd_chk(4'h2, 8'h31);
    rd_chk(4'h3, 8'h10);
    rd_chk(4'h4, 8'h80);
    wr_reg(4'h3, 8'h11);
    rd_chk(4'h2, 8'h71);
    wr_reg(4'h4, 8'h88);
    wr_reg(4'h2, 8'h3f);
    req_chk(1, 8'hf8);
    rd_chk(4'h2, 8'hff);
    $display("test timebase done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pins;
    t_autoconv;
    t_timebase;
    give_verdict;
  end
  // The tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    give_verdict;
  end
endmodule
